// ==== logic/dbm_match_unit.sv ====
// Breakpoint match unit with APB register access
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module dbm_match_unit #(
	parameter int NBP = dbm_pkg::NUM_BP
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Core mode for the privilege check
	input wire logic real_mode_i,
	input wire logic [1:0] cpl_i,
	// Instruction fetch side
	input wire logic insn_valid_i,
	input wire logic [31:0] insn_addr_i,
	// Data operand side
	input wire logic data_valid_i,
	input wire logic data_write_i,
	input wire logic [31:0] data_addr_i,
	input wire logic [1:0] data_size_i,
	input wire logic insn_done_i,
	input wire logic operands_done_i,
	input wire logic task_switch_i,
	// Exception requests to the core
	output logic fault_o,
	output logic trap_o,
	output logic hold_next_o
);
	import dbm_pkg::*;

	logic [31:0] bp_address_reg [NBP];
	logic [31:0] bp_control_reg;
	logic [31:0] bp_status_reg;
	logic [NBP-1:0] pend_hits;
	logic pend_valid;

	wire access_phase = psel_i & penable_i;
	wire privileged = real_mode_i | (cpl_i == 2'h0);
	wire debug_reg_guard = bp_control_reg[CTL_GUARD_POS];
	// Guard refuses even privileged callers, and is itself the event
	wire refuse = access_phase & (~privileged | debug_reg_guard);
	wire guard_event = access_phase & pready_o & debug_reg_guard;
	wire ok_acc = access_phase & ~refuse;
	wire sel_ctl = paddr_i == ADDR_CONTROL;
	wire sel_sts = paddr_i == ADDR_STATUS;
	wire [1:0] bp_idx = paddr_i[3:2];
	wire sel_bp = paddr_i[7:4] == 4'h0;
	// Spare words 0x10 and 0x14 read as zero without an error
	wire mapped = paddr_i[7:5] == 3'h0;
	// Writes land only at the edge that answers the access
	wire wr_ok = ok_acc & pwrite_i & mapped & pready_o;
	wire system_exact_match = bp_control_reg[CTL_SYS_EXACT_POS];
	wire per_task_exact_match = bp_control_reg[CTL_TASK_EXACT_POS];

	logic [NBP-1:0] insn_hit;
	logic [NBP-1:0] data_hit;
	// Per breakpoint comparators
	genvar g;
	generate
		for (g = 0; g < NBP; g++) begin : g_bp
			wire en = bp_control_reg[2*g+CTL_SYS_EN_POS] |
				bp_control_reg[2*g+CTL_TASK_EN_POS];
			wire [1:0] access_type_sel = bp_control_reg[CTL_TYPE_POS+4*g +: 2];
			wire [1:0] match_size_sel = bp_control_reg[CTL_SIZE_POS+4*g +: 2];
			// Size 10 is left unaligned like a byte; software must avoid it
			wire [31:0] mask = (match_size_sel == SIZE_DWORD) ? 32'hffff_fffc :
				(match_size_sel == SIZE_WORD) ? 32'hffff_fffe :
				32'hffff_ffff;
			wire [31:0] lo = bp_address_reg[g] & mask;
			wire [31:0] hi = lo | ~mask;
			// Access spans first..last byte; any overlap with the field hits
			wire [31:0] last = data_addr_i + {30'h0, data_size_i};
			wire overlap = (data_addr_i <= hi) & (last >= lo);
			wire data_kind = (access_type_sel == TYPE_RDWR) |
				((access_type_sel == TYPE_WRITE) & data_write_i);
			assign insn_hit[g] = en & insn_valid_i &
				(access_type_sel == TYPE_EXEC) &
				(insn_addr_i == bp_address_reg[g]);
			assign data_hit[g] = en & data_valid_i & data_kind & overlap;
		end
	endgenerate

	wire any_insn = |insn_hit;
	wire trap_now = pend_valid & insn_done_i & operands_done_i;
	wire [31:0] next_control = task_switch_i ?
		(pwdata_i & ~(32'h1 << CTL_TASK_EXACT_POS)) : pwdata_i;

	// Register writes and control updates
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bp_control_reg <= CONTROL_RESET;
			for (int i = 0; i < NBP; i++) begin
				bp_address_reg[i] <= ADDR_RESET;
			end
		end else if (clk_en_i) begin
			if (wr_ok && sel_ctl) begin
				bp_control_reg <= next_control;
			end else if (task_switch_i) begin
				bp_control_reg[CTL_TASK_EXACT_POS] <= 1'b0;
			end
			if (wr_ok && sel_bp) begin
				bp_address_reg[bp_idx] <= pwdata_i;
			end
		end
	end

	// Sticky status; a new event outranks a software clear
	logic [31:0] sts_clear;
	logic [31:0] sts_set;
	assign sts_clear = (wr_ok && sel_sts) ? ~pwdata_i : 32'hffff_ffff;
	assign sts_set = {18'h0, guard_event, 9'h0,
		({NBP{any_insn}} & insn_hit) | ({NBP{trap_now}} & pend_hits)};
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bp_status_reg <= STATUS_RESET;
		end else if (clk_en_i) begin
			bp_status_reg <= (bp_status_reg & sts_clear) | sts_set;
		end
	end

	// Data hits wait for instruction end before the trap is raised
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_hits <= '0;
			pend_valid <= 1'b0;
			fault_o <= 1'b0;
			trap_o <= 1'b0;
			hold_next_o <= 1'b0;
		end else if (clk_en_i) begin
			fault_o <= any_insn;
			trap_o <= trap_now;
			if (trap_now) begin
				pend_hits <= data_hit;
				pend_valid <= |data_hit;
			end else begin
				pend_hits <= pend_hits | data_hit;
				pend_valid <= pend_valid | (|data_hit);
			end
			hold_next_o <= (pend_valid & ~trap_now) | (|data_hit);
		end
	end

	// APB answer: one wait state, read data registered
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		if (sel_ctl) begin
			rd_mux = bp_control_reg;
		end else if (sel_sts) begin
			rd_mux = bp_status_reg;
		end else if (sel_bp) begin
			rd_mux = bp_address_reg[bp_idx];
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0;
		end else if (clk_en_i) begin
			pready_o <= access_phase & ~pready_o;
			pslverr_o <= access_phase & ~pready_o & (refuse | ~mapped);
			prdata_o <= (ok_acc & ~pwrite_i & ~pready_o) ? rd_mux : 32'h0;
		end
	end
endmodule

// ==== common/dbm_pkg.sv ====
// Package of constants for the breakpoint match unit
package dbm_pkg;
	localparam int NUM_BP = 4;
	localparam logic [7:0] ADDR_BP0 = 8'h00;
	localparam logic [7:0] ADDR_BP1 = 8'h04;
	localparam logic [7:0] ADDR_BP2 = 8'h08;
	localparam logic [7:0] ADDR_BP3 = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_CONTROL = 8'h1c;
	// Control field positions
	localparam int CTL_SYS_EN_POS = 1;
	localparam int CTL_TASK_EN_POS = 0;
	localparam int CTL_TASK_EXACT_POS = 8;
	localparam int CTL_SYS_EXACT_POS = 9;
	localparam int CTL_GUARD_POS = 13;
	localparam int CTL_TYPE_POS = 16;
	localparam int CTL_SIZE_POS = 18;
	// Status field positions
	localparam int STS_HIT_POS = 0;
	localparam int STS_GUARD_POS = 13;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
	localparam logic [1:0] TYPE_EXEC = 2'h0;
	localparam logic [1:0] TYPE_WRITE = 2'h1;
	localparam logic [1:0] TYPE_RDWR = 2'h3;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_DWORD = 2'h3;
endpackage

// ==== testbench/dbm_match_unit_properties.sv ====
// Port checker of the breakpoint match unit
`timescale 1ns/1ps
module dbm_props (
	input wire logic clock_i, rst_n_i, psel_i, penable_i, real_mode_i,
	input wire logic insn_valid_i, data_valid_i, insn_done_i,
	input wire logic operands_done_i, pready_o, pslverr_o,
	input wire logic fault_o, trap_o, hold_next_o,
	input wire logic [1:0] cpl_i,
	input wire logic [31:0] prdata_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	AST_FLT: assert property (fault_o |-> $past(insn_valid_i))
		else $error("fault without instruction");
	AST_TRP: assert property (trap_o |-> $past(insn_done_i && operands_done_i))
		else $error("trap before completion");
	AST_HLD: assert property ($rose(hold_next_o) |-> $past(data_valid_i))
		else $error("hold without operand access");
	AST_WAIT: assert property (hold_next_o &&
		!(insn_done_i && operands_done_i) |=> hold_next_o)
		else $error("hold dropped early");
	AST_END: assert property (trap_o |-> !hold_next_o || $past(data_valid_i))
		else $error("hold kept after trap");
	AST_REF: assert property (pready_o && !$past(real_mode_i) &&
		$past(cpl_i) != 2'h0 |-> pslverr_o)
		else $error("unprivileged access accepted");
	AST_ANS: assert property (psel_i && penable_i && !pready_o |=> pready_o)
		else $error("no answer after one wait state");
	AST_IDLE: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
		else $error("bus outputs not idle");
	cover property (fault_o);
	cover property (trap_o);
	cover property (pslverr_o);
endmodule
bind dbm_match_unit dbm_props chk_u (.*);

// ==== testbench/dbm_core_model.sv ====
// Core model that ends a held instruction once operands drain
`timescale 1ns/1ps
module dbm_core_model (
	input wire logic clock_i, hold_i,
	output logic done_o
);
	logic [1:0] cnt;
	// Operands drain slowly, so the trap must really wait for them
	always_ff @(posedge clock_i) begin
		cnt <= hold_i ? cnt + 2'h1 : 2'h0;
	end
	assign done_o = cnt == 2'h2;
endmodule

// ==== testbench/dbm_match_unit_bench.sv ====
// Self-checking bench of the breakpoint match unit
`timescale 1ns/1ps
module dbm_match_unit_bench;
	import dbm_pkg::*;
	logic clock_i = '0, rst_n_i = '0, clk_en_i = '1, psel_i = '0, e;
	logic penable_i = '0, pwrite_i = '0, real_mode_i = '1, insn_valid_i = '0;
	logic data_valid_i = '0, data_write_i = '0, task_switch_i = '0;
	logic pready_o, pslverr_o, fault_o, trap_o, hold_next_o, insn_done_i;
	wire operands_done_i = insn_done_i;
	logic [1:0] cpl_i = '0, data_size_i = '0;
	logic [7:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0, insn_addr_i = '0, data_addr_i = '0, prdata_o, q;
	int n_mismatch = 0, compares = 0, cyc = 0;
	always #12.5 clock_i = ~clock_i;
	dbm_match_unit dut_u (.*);
	dbm_core_model core_u (.clock_i(clock_i), .hold_i(hold_next_o),
		.done_o(insn_done_i));
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, x, s);
		end
	endtask
	task wrap_up;
		if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
		@(posedge clock_i) penable_i <= 1;
		do @(posedge clock_i); while (pready_o !== 1'b1);
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
		@(posedge clock_i);
	endtask
	task ins(input logic [31:0] a, input logic x);
		insn_valid_i <= 1; insn_addr_i <= a;
		@(posedge clock_i) insn_valid_i <= 0;
		@(negedge clock_i) chk("fault", fault_o, x);
		@(posedge clock_i);
	endtask
	task dat(input logic [31:0] a, input logic w, input logic [1:0] s, x);
		data_valid_i <= 1; data_addr_i <= a; data_write_i <= w;
		data_size_i <= s;
		e = 0;
		@(posedge clock_i) data_valid_i <= 0;
		repeat (6) @(negedge clock_i) if (trap_o === 1'b1) e = 1;
		chk("trap", e, x);
		@(posedge clock_i);
	endtask
	task t_reset;
		apb(0, ADDR_CONTROL, 0); chk("control", q, CONTROL_RESET);
		apb(0, ADDR_STATUS, 0); chk("status", q, STATUS_RESET);
		ins(ADDR_RESET, 0);
	endtask
	task t_insn;
		apb(1, ADDR_BP0, 32'h0000_1000);
		apb(1, ADDR_BP1, 32'h0000_2002);
		// Local enable on one, global on the other; exact bits left clear
		apb(1, ADDR_CONTROL, 32'h0000_0009);
		ins(32'h0000_1000, 1);
		ins(32'h0000_2002, 1);
		ins(32'h0000_2000, 0);
		apb(0, ADDR_STATUS, 0); chk("insn status", q, 32'h3);
		apb(1, ADDR_STATUS, 32'h3);
	endtask
	task t_data;
		apb(1, ADDR_BP2, 32'h0000_0105);
		apb(1, ADDR_BP3, 32'h0000_0203);
		apb(1, ADDR_CONTROL, 32'hf500_0060);
		dat(32'h0000_0104, 1, 2'h0, 1);
		apb(0, ADDR_STATUS, 0); chk("status", q, 32'h4);
		dat(32'h0000_0104, 0, 2'h0, 0);
		apb(0, ADDR_STATUS, 0); chk("sticky", q, 32'h4);
		apb(1, ADDR_STATUS, 32'h4);
		apb(0, ADDR_STATUS, 0); chk("cleared", q, 32'h0);
		dat(32'h0000_0200, 0, 2'h0, 1);
		dat(32'h0000_01fe, 1, 2'h1, 0);
	endtask
	task t_task;
		apb(1, ADDR_CONTROL, 32'h0000_0300);
		task_switch_i <= 1;
		@(posedge clock_i) task_switch_i <= 0;
		apb(0, ADDR_CONTROL, 0); chk("exact", q, 32'h0000_0200);
	endtask
	task t_guard;
		apb(0, 8'h40, 0); chk("unmapped", e, 1);
		real_mode_i <= 0; cpl_i <= 2'h3;
		apb(0, ADDR_CONTROL, 0); chk("level3", e, 1);
		cpl_i <= 2'h0;
		apb(1, ADDR_CONTROL, 32'h0000_2000); chk("level0", e, 0);
		real_mode_i <= 1;
		apb(0, ADDR_CONTROL, 0); chk("guard", e, 1);
	endtask
	always @(posedge clock_i) if (++cyc == 3000) begin
		n_mismatch++;
		wrap_up;
	end
	initial begin
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1;
		@(posedge clock_i);
		t_reset;
		t_insn;
		t_data;
		t_task;
		t_guard;
		wrap_up;
	end
endmodule
